// [core/aje_pkg.sv]
// shared types and constants for the arithmetic, logic and jump executor
package aje_pkg;
    // ----------------------------------------
    // widths and opcodes
    // ----------------------------------------
    localparam int W = 30;
    localparam int AW = 15;
    localparam int NCH = 8;
    localparam logic [5:0] OP_ADDQ = 6'h16;
    localparam logic [5:0] OP_SUBQ = 6'h17;
    localparam logic [5:0] OP_EYPQ = 6'h18;
    localparam logic [5:0] OP_EYMQ = 6'h19;
    localparam logic [5:0] OP_SAPQ = 6'h1a;
    localparam logic [5:0] OP_SAMQ = 6'h1b;
    localparam logic [5:0] OP_RYPQ = 6'h1c;
    localparam logic [5:0] OP_RYMQ = 6'h1d;
    localparam logic [5:0] OP_RYP1 = 6'h1e;
    localparam logic [5:0] OP_RYM1 = 6'h1f;
    localparam logic [5:0] OP_ELP = 6'h20;
    localparam logic [5:0] OP_ALP = 6'h21;
    localparam logic [5:0] OP_SLP = 6'h22;
    localparam logic [5:0] OP_CMPM = 6'h23;
    localparam logic [5:0] OP_RLP = 6'h24;
    localparam logic [5:0] OP_RALP = 6'h25;
    localparam logic [5:0] OP_RSLP = 6'h26;
    localparam logic [5:0] OP_STLP = 6'h27;
    localparam logic [5:0] OP_SSET = 6'h28;
    localparam logic [5:0] OP_SCPL = 6'h29;
    localparam logic [5:0] OP_SCLR = 6'h2a;
    localparam logic [5:0] OP_SSUB = 6'h2b;
    localparam logic [5:0] OP_RSET = 6'h2c;
    localparam logic [5:0] OP_RCPL = 6'h2d;
    localparam logic [5:0] OP_RCLR = 6'h2e;
    localparam logic [5:0] OP_RSUB = 6'h2f;
    localparam logic [5:0] OP_JMPA = 6'h30;
    localparam logic [5:0] OP_JMPM = 6'h31;
    localparam logic [5:0] OP_JBIN = 6'h32;
    localparam logic [5:0] OP_JBOUT = 6'h33;
    localparam logic [5:0] OP_RJMP = 6'h34;
    localparam logic [2:0] FORM_FULL = 3'h3;
    localparam logic [W-1:0] ONE = 30'h00000001;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic [5:0]    op;
        logic [2:0]    j;
        logic [2:0]    k;
        logic [AW-1:0] y;
        logic [W-1:0]  opnd;
    } aje_instr_t;

    typedef struct packed {
        logic          v;
        logic [W-1:0]  a;
        logic [W-1:0]  q;
        logic [AW-1:0] p;
    } aje_preset_t;

    typedef struct packed {
        logic          v;
        logic          lower;
        logic [2:0]    form;
        logic [AW-1:0] addr;
        logic [W-1:0]  data;
    } aje_store_t;

    typedef struct packed {
        logic [W-1:0]  a;
        logic [W-1:0]  q;
        logic [AW-1:0] p;
        aje_store_t    st;
        logic          done;
        logic          skip;
        logic          jump;
        logic          ie_set;
        logic          stop;
        logic [5:0]    k1;
        logic [5:0]    k2;
        logic [5:0]    k3;
        logic [5:0]    keys;
    } aje_state_t;

    localparam aje_state_t RST_STATE = '0;
endpackage

// [core/aje_exec.sv]
// executes opcodes 26 through 64 on the sum, second and counter registers
// Functional notes
// - ops 26/27 skip by j: never, always, A pos/neg, Q zero/nonzero/pos/neg.
// - op 30 sets A to Q plus operand.
// - op 31 sets A to complement of Q minus operand.
// - ops 32/33 add/subtract Q into A, store A in form k.
// - ops 34/35 Q plus/minus memory word, 35 complemented, stored back.
// - ops 36/37 one plus/minus memory word, 37 complemented, stored back.
// - op 40 A gets operand AND Q; j 2/3 skip on even/odd parity.
// - ops 41/42 add/subtract operand AND Q to/from A.
// - op 43 skips on A minus masked operand, registers unchanged.
// - op 44 A gets word AND Q, stored back, parity skips.
// - ops 45/46 add/subtract word AND Q into A, stored back.
// - op 47 stores A AND Q in form k, no register changes.
// - ops 50/51/52 set, invert, clear A bits where operand is one.
// - op 53 copies operand bits into A where Q is one.
// - ops 54/55/56 selective set/invert/clear by word, stored back.
// - op 57 substitutes word bits under Q mask into A, stored back.
// - op 60 j 0 no jump, j 1 jump; both set interrupt enable.
// - op 60 j 2..7 jump on Q pos/neg, A zero/nonzero/pos/neg.
// - a taken jump of ops 60..63 loads counter with target y, else sequential.
// - op 61 j 0 jumps, j 1..3 jump by jump keys; j 4 jumps and stops, j 5..7 jump then stop by stop keys.
// - ops 62/63 jump when selected channel's input/output buffer active.
// - op 64 on a taken j condition (op 60 table) stores counter plus one in lower half, continues at target plus one.
// - sum and second registers are 30 bits each, a 60-bit pair.
`timescale 1ns/10ps
module aje_exec (
    input  wire logic             MCLK,
    input  wire logic             SRST,
    input  wire logic             CE,
    input  wire logic             GO,
    input  wire aje_pkg::aje_instr_t  INSTR,
    input  wire aje_pkg::aje_preset_t PRESET,
    input  wire logic [2:0]       JUMP_KEY,
    input  wire logic [2:0]       STOP_KEY,
    input  wire logic [7:0]       IN_BUF_ACT,
    input  wire logic [7:0]       OUT_BUF_ACT,
    output logic [29:0]           A_REG,
    output logic [29:0]           Q_REG,
    output logic [14:0]           P_REG,
    output aje_pkg::aje_store_t   STORE,
    output logic                  DONE,
    output logic                  SKIPPED,
    output logic                  JUMPED,
    output logic                  INT_EN_SET,
    output logic                  STOP_REQ
);
    import aje_pkg::*;

    // ----------------------------------------
    // ones complement helpers
    // ----------------------------------------
    function automatic logic [W-1:0] oc_add(input logic [W-1:0] x, input logic [W-1:0] y);
        logic [W:0] s;
        s = {1'b0, x} + {1'b0, y};
        return s[W-1:0] + {{(W-1){1'b0}}, s[W]};
    endfunction

    function automatic logic [W-1:0] oc_sub(input logic [W-1:0] x, input logic [W-1:0] y);
        return oc_add(x, ~y);
    endfunction

    function automatic logic is_zero(input logic [W-1:0] x);
        return (x == '0) || (x == '1);
    endfunction

    function automatic logic skip_tab(input logic [2:0] j, input logic [W-1:0] a,
                                      input logic [W-1:0] q);
        logic c;
        c = 1'b0;
        unique case (j)
            3'h0: c = 1'b0;
            3'h1: c = 1'b1;
            3'h2: c = ~a[W-1];
            3'h3: c = a[W-1];
            3'h4: c = is_zero(q);
            3'h5: c = ~is_zero(q);
            3'h6: c = ~q[W-1];
            3'h7: c = q[W-1];
        endcase
        return c;
    endfunction

    function automatic logic jump_tab(input logic [2:0] j, input logic [W-1:0] a,
                                      input logic [W-1:0] q);
        logic c;
        c = 1'b0;
        unique case (j)
            3'h0: c = 1'b0;
            3'h1: c = 1'b1;
            3'h2: c = ~q[W-1];
            3'h3: c = q[W-1];
            3'h4: c = is_zero(a);
            3'h5: c = ~is_zero(a);
            3'h6: c = ~a[W-1];
            3'h7: c = a[W-1];
        endcase
        return c;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    aje_state_t r;
    aje_state_t n;
    logic [W-1:0] y_r;
    logic [W-1:0] lp_r;
    logic [W-1:0] d_r;
    logic         sk;
    logic         jp;
    logic         rj;
    logic         st;
    logic         st_k;
    logic [2:0]   j_r;

    always_comb begin
        y_r = INSTR.opnd;
        j_r = INSTR.j;
        lp_r = INSTR.opnd & r.q;
        d_r = '0;
        sk = 1'b0;
        jp = 1'b0;
        rj = 1'b0;
        st = 1'b0;
        st_k = 1'b0;
        n = r;
        n.st.v = 1'b0;
        n.st.lower = 1'b0;
        n.done = 1'b0;
        n.skip = 1'b0;
        n.jump = 1'b0;
        n.ie_set = 1'b0;
        n.stop = 1'b0;
        // console keys: three stages, accepted when the last two agree
        n.k1 = {STOP_KEY, JUMP_KEY};
        n.k2 = r.k1;
        n.k3 = r.k2;
        if (r.k2 == r.k3) begin
            n.keys = r.k3;
        end
        if (PRESET.v) begin
            n.a = PRESET.a;
            n.q = PRESET.q;
            n.p = PRESET.p;
        end else if (GO) begin
            sk = skip_tab(j_r, r.a, r.q);
            unique case (INSTR.op)
                OP_ADDQ: begin
                    n.q = oc_add(r.q, y_r);
                    sk = skip_tab(j_r, r.a, n.q);
                end
                OP_SUBQ: begin
                    n.q = oc_sub(r.q, y_r);
                    sk = skip_tab(j_r, r.a, n.q);
                end
                OP_EYPQ: n.a = oc_add(r.q, y_r);
                OP_EYMQ: n.a = ~oc_sub(r.q, y_r);
                OP_SAPQ: begin
                    n.a = oc_add(r.a, r.q);
                    st_k = 1'b1;
                end
                OP_SAMQ: begin
                    n.a = oc_sub(r.a, r.q);
                    st_k = 1'b1;
                end
                OP_RYPQ: begin
                    n.a = oc_add(r.q, y_r);
                    st = 1'b1;
                end
                OP_RYMQ: begin
                    n.a = ~oc_sub(r.q, y_r);
                    st = 1'b1;
                end
                OP_RYP1: begin
                    n.a = oc_add(ONE, y_r);
                    st = 1'b1;
                end
                OP_RYM1: begin
                    n.a = ~oc_sub(ONE, y_r);
                    st = 1'b1;
                end
                OP_ELP, OP_RLP: begin
                    n.a = lp_r;
                    st = (INSTR.op == OP_RLP);
                    if (j_r == 3'h2) begin
                        sk = ~^lp_r;
                    end else if (j_r == 3'h3) begin
                        sk = ^lp_r;
                    end else begin
                        sk = skip_tab(j_r, n.a, r.q);
                    end
                end
                OP_ALP, OP_RALP: begin
                    n.a = oc_add(r.a, lp_r);
                    st = (INSTR.op == OP_RALP);
                end
                OP_SLP, OP_RSLP: begin
                    n.a = oc_sub(r.a, lp_r);
                    st = (INSTR.op == OP_RSLP);
                end
                OP_CMPM: begin
                    d_r = oc_sub(r.a, lp_r);
                    sk = skip_tab(j_r, d_r, r.q);
                end
                OP_STLP: begin
                    st_k = 1'b1;
                end
                OP_SSET, OP_RSET: begin
                    n.a = r.a | y_r;
                    st = (INSTR.op == OP_RSET);
                end
                OP_SCPL, OP_RCPL: begin
                    n.a = r.a ^ y_r;
                    st = (INSTR.op == OP_RCPL);
                end
                OP_SCLR, OP_RCLR: begin
                    n.a = r.a & ~y_r;
                    st = (INSTR.op == OP_RCLR);
                end
                OP_SSUB, OP_RSUB: begin
                    n.a = (r.a & ~r.q) | lp_r;
                    st = (INSTR.op == OP_RSUB);
                end
                OP_JMPA: begin
                    sk = 1'b0;
                    jp = jump_tab(j_r, r.a, r.q);
                    n.ie_set = (j_r <= 3'h1);
                end
                OP_JMPM: begin
                    sk = 1'b0;
                    jp = (j_r == 3'h0) || j_r[2] || r.keys[j_r[1:0] - 2'h1];
                    n.stop = (j_r == 3'h4) || (j_r[2] && r.keys[j_r[1:0] + 3'h2]);
                end
                OP_JBIN: begin
                    sk = 1'b0;
                    jp = IN_BUF_ACT[j_r];
                end
                OP_JBOUT: begin
                    sk = 1'b0;
                    jp = OUT_BUF_ACT[j_r];
                end
                OP_RJMP: begin
                    sk = 1'b0;
                    rj = jump_tab(j_r, r.a, r.q);
                end
                default: sk = 1'b0;
            endcase
            if (st || st_k) begin
                n.st.v = 1'b1;
                n.st.addr = INSTR.y;
                n.st.form = st_k ? INSTR.k : FORM_FULL;
                n.st.data = (INSTR.op == OP_STLP) ? (r.a & r.q) : n.a;
            end
            if (rj) begin
                n.st.v = 1'b1;
                n.st.lower = 1'b1;
                n.st.addr = INSTR.y;
                n.st.form = FORM_FULL;
                n.st.data = {15'h0000, AW'(r.p + 15'h0001)};
                n.p = AW'(INSTR.y + 15'h0001);
            end else if (jp) begin
                n.p = INSTR.y;
            end else if (sk) begin
                n.p = AW'(r.p + 15'h0002);
            end else begin
                n.p = AW'(r.p + 15'h0001);
            end
            n.skip = sk;
            n.jump = jp || rj;
            n.done = 1'b1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            r <= RST_STATE;
        end else if (CE) begin
            r <= n;
        end
    end

    // 60-bit pair view of the two registers
    assign {A_REG, Q_REG} = {r.a, r.q};
    assign P_REG = r.p;
    assign STORE = r.st;
    assign DONE = r.done;
    assign SKIPPED = r.skip;
    assign JUMPED = r.jump;
    assign INT_EN_SET = r.ie_set;
    assign STOP_REQ = r.stop;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);

    logic gv;
    assign gv = GO && CE && !PRESET.v;

    a_enter_sum: assert property (gv && INSTR.op == OP_EYPQ |=>
        A_REG == oc_add($past(Q_REG), $past(INSTR.opnd)))
        else $error("enter sum wrong");
    a_replace_dec: assert property (gv && INSTR.op == OP_RYM1 |=>
        STORE.v && STORE.data == ~oc_sub(ONE, $past(INSTR.opnd)))
        else $error("decrement store wrong");
    a_compare_keep: assert property (gv && INSTR.op == OP_CMPM |=>
        A_REG == $past(A_REG) && Q_REG == $past(Q_REG) && !STORE.v)
        else $error("compare masked changed state");
    a_parity_even: assert property (gv && INSTR.op == OP_ELP && INSTR.j == 3'h2 |=>
        SKIPPED == ~^A_REG && P_REG == AW'($past(P_REG) + (SKIPPED ? 15'h0002 : 15'h0001)))
        else $error("parity skip wrong");
    a_sel_subst: assert property (gv && INSTR.op == OP_SSUB |=>
        ((A_REG ^ $past(A_REG)) & ~Q_REG) == '0)
        else $error("substitute touched unmasked bit");
    a_jump_load: assert property (gv && INSTR.op == OP_JMPA && INSTR.j == 3'h1 |=>
        P_REG == $past(INSTR.y) && INT_EN_SET && JUMPED)
        else $error("unconditional jump wrong");
    a_no_jump: assert property (gv && INSTR.op == OP_JMPA && INSTR.j == 3'h0 |=>
        P_REG == AW'($past(P_REG) + 15'h0001) && INT_EN_SET && !JUMPED)
        else $error("j0 jumped");
    a_return_jump: assert property (gv && INSTR.op == OP_RJMP && INSTR.j == 3'h1 |=>
        STORE.v && STORE.lower && STORE.data[14:0] == AW'($past(P_REG) + 15'h0001)
        && P_REG == AW'($past(INSTR.y) + 15'h0001))
        else $error("return jump wrong");
    a_stop_four: assert property (gv && INSTR.op == OP_JMPM && INSTR.j == 3'h4 |=>
        STOP_REQ && JUMPED ##1 (!STOP_REQ || $past(gv) || !$past(CE)))
        else $error("stop four wrong");
    a_skip_two: assert property (gv && INSTR.op == OP_ADDQ && INSTR.j == 3'h1 |=>
        P_REG == AW'($past(P_REG) + 15'h0002))
        else $error("skip did not advance two");

    c_ret_jump: cover property (gv && INSTR.op == OP_RJMP ##1 STORE.v);
    c_buf_jump: cover property (gv && INSTR.op == OP_JBIN ##1 JUMPED);
    c_stop_key: cover property (gv && INSTR.op == OP_JMPM && INSTR.j == 3'h6 ##1 STOP_REQ);
endmodule

// [tb/aje_mem_model.sv]
// core storage and console key model facing the executor
`timescale 1ns/10ps
module aje_mem_model (
    input  wire logic                mclk,
    input  wire aje_pkg::aje_store_t store,
    input  wire logic [2:0]          jsel,
    input  wire logic [2:0]          ssel,
    input  wire logic [7:0]          rd_addr,
    output logic [2:0]               jump_key,
    output logic [2:0]               stop_key,
    output logic [29:0]              rd_word
);
    import aje_pkg::*;
    // ----------------------------------------
    // storage and keys
    // ----------------------------------------
    logic [W-1:0] mem [0:255];
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 30'h2aaaaaaa;
        end
    end
    assign jump_key = jsel;
    assign stop_key = ssel;
    assign rd_word  = mem[rd_addr];
    // lower writes keep the upper half intact
    always @(posedge mclk) begin
        if (store.v === 1'b1) begin
            if (store.lower) begin
                mem[store.addr[7:0]][14:0] <= store.data[14:0];
            end else begin
                mem[store.addr[7:0]] <= store.data;
            end
        end
    end
endmodule

// [tb/tb_arith_logic_jump_exec.sv]
// self-checking bench for the arithmetic, logic and jump executor
`timescale 1ns/10ps
`define CHK(g, e) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); \
    end \
end
module tb_arith_logic_jump_exec;
    import aje_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam logic [AW-1:0] P0 = 15'h010;
    localparam logic          F = 1'b0;
    localparam logic          T = 1'b1;
    localparam logic [7:0]    TBL = 8'h6a;
    localparam logic [7:0]    KT = 8'hf5;
    logic          mclk = 1'b0;
    logic          srst = 1'b1;
    logic          ce = 1'b1;
    logic          go = 1'b0;
    aje_instr_t    instr = '0;
    aje_preset_t   preset = '0;
    logic [2:0]    jsel = 3'h0;
    logic [2:0]    ssel = 3'h0;
    logic [7:0]    in_act = 8'h00;
    logic [7:0]    out_act = 8'h00;
    logic [2:0]    jkey;
    logic [2:0]    skey;
    logic [W-1:0]  a_reg;
    logic [W-1:0]  q_reg;
    logic [W-1:0]  rd_word;
    logic [AW-1:0] p_reg;
    aje_store_t    store;
    logic          done;
    logic          skipped;
    logic          jumped;
    logic          ie_set;
    logic          stop_req;
    logic [AW-1:0] yv = 15'h020;
    logic [AW-1:0] pexp = P0;
    logic [AW-1:0] last = '0;
    int            mismatches = 0;
    int            samples_checked = 0;

    always #5 mclk = ~mclk;

    aje_exec dut_u (.MCLK(mclk), .SRST(srst), .CE(ce), .GO(go), .INSTR(instr),
        .PRESET(preset), .JUMP_KEY(jkey), .STOP_KEY(skey), .IN_BUF_ACT(in_act),
        .OUT_BUF_ACT(out_act), .A_REG(a_reg), .Q_REG(q_reg), .P_REG(p_reg), .STORE(store),
        .DONE(done), .SKIPPED(skipped), .JUMPED(jumped), .INT_EN_SET(ie_set),
        .STOP_REQ(stop_req));
    aje_mem_model mem_u (.mclk(mclk), .store(store), .jsel(jsel), .ssel(ssel),
        .rd_addr(8'h40), .jump_key(jkey), .stop_key(skey), .rd_word(rd_word));

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic pre(input logic [W-1:0] a, input logic [W-1:0] q);
        preset = '{v: 1'b1, a: a, q: q, p: P0};
        pexp = P0;
        @(posedge mclk);
        #1;
        preset.v = 1'b0;
        @(posedge mclk);
        #1;
    endtask

    task automatic ex(input logic [5:0] op, input logic [2:0] j, input logic [2:0] k,
        input logic [W-1:0] opnd, input logic [W-1:0] ea, input logic [W-1:0] eq,
        input logic sk, input logic jm, input logic sv, input logic [W-1:0] sd);
        logic [AW-1:0] ep;
        logic [2:0]    ef;
        ep = jm ? ((op == OP_RJMP) ? yv + 15'h1 : yv) : (sk ? pexp + 15'h2 : pexp + 15'h1);
        ef = (op == OP_SAPQ || op == OP_SAMQ || op == OP_STLP) ? k : FORM_FULL;
        instr = '{op: op, j: j, k: k, y: yv, opnd: opnd};
        go = 1'b1;
        @(posedge mclk);
        #1;
        `CHK(a_reg, ea);
        `CHK(q_reg, eq);
        `CHK(p_reg, ep);
        `CHK({done, skipped, jumped}, {T, sk, jm});
        `CHK(ie_set, op == OP_JMPA && j < 3'h2);
        `CHK(stop_req, op == OP_JMPM && j >= 3'h4 && (j == 3'h4 || ssel[j - 3'h5]));
        `CHK(store.v, sv);
        if (sv) begin
            `CHK({store.lower, store.form, store.addr}, {op == OP_RJMP, ef, yv});
            `CHK(store.data, sd);
        end
        pexp = ep;
        go = 1'b0;
        @(posedge mclk);
        #1;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge mclk);
        #1;
        srst = 1'b0;
        `CHK({a_reg, q_reg, p_reg, done, store.v}, '0);
        pre(30'h100, 30'h2);
        ex(OP_EYPQ, 3'h0, 3'h0, 30'h5, 30'h7, 30'h2, F, F, F, '0);
        ex(OP_SAPQ, 3'h0, 3'h1, 30'h0, 30'h9, 30'h2, F, F, T, 30'h9);
        ex(OP_SAMQ, 3'h0, 3'h6, 30'h0, 30'h7, 30'h2, F, F, T, 30'h7);
        ex(OP_RYPQ, 3'h0, 3'h3, 30'h5, 30'h7, 30'h2, F, F, T, 30'h7);
        ex(OP_RYP1, 3'h0, 3'h3, 30'h5, 30'h6, 30'h2, F, F, T, 30'h6);
        ex(OP_RYM1, 3'h0, 3'h3, 30'h5, 30'h4, 30'h2, F, F, T, 30'h4);
        pre(30'h100, 30'h7);
        ex(OP_EYMQ, 3'h0, 3'h0, 30'h5, 30'h3ffffffd, 30'h7, F, F, F, '0);
        ex(OP_RYMQ, 3'h0, 3'h3, 30'h5, 30'h3ffffffd, 30'h7, F, F, T, 30'h3ffffffd);
        $display("test arithmetic done");
        ex(OP_ELP, 3'h2, 3'h0, 30'hf, 30'h7, 30'h7, F, F, F, '0);
        ex(OP_ELP, 3'h3, 3'h0, 30'hf, 30'h7, 30'h7, T, F, F, '0);
        ex(OP_RLP, 3'h2, 3'h3, 30'h3, 30'h3, 30'h7, T, F, T, 30'h3);
        ex(OP_ALP, 3'h0, 3'h0, 30'hf, 30'ha, 30'h7, F, F, F, '0);
        ex(OP_SLP, 3'h0, 3'h0, 30'hc, 30'h6, 30'h7, F, F, F, '0);
        ex(OP_CMPM, 3'h3, 3'h0, 30'hf, 30'h6, 30'h7, T, F, F, '0);
        ex(OP_RALP, 3'h0, 3'h3, 30'h5, 30'hb, 30'h7, F, F, T, 30'hb);
        ex(OP_RSLP, 3'h0, 3'h3, 30'h3, 30'h8, 30'h7, F, F, T, 30'h8);
        pre(30'hf, 30'h3c);
        ex(OP_STLP, 3'h0, 3'h2, 30'h0, 30'hf, 30'h3c, F, F, T, 30'hc);
        $display("test logical product done");
        pre(30'hf0, 30'h3c);
        ex(OP_SSET, 3'h0, 3'h0, 30'h3c, 30'hfc, 30'h3c, F, F, F, '0);
        ex(OP_SCPL, 3'h0, 3'h0, 30'h3c, 30'hc0, 30'h3c, F, F, F, '0);
        ex(OP_SCLR, 3'h0, 3'h0, 30'hc0, 30'h0, 30'h3c, F, F, F, '0);
        ex(OP_SSUB, 3'h0, 3'h0, 30'hf, 30'hc, 30'h3c, F, F, F, '0);
        ex(OP_RSET, 3'h0, 3'h3, 30'h30, 30'h3c, 30'h3c, F, F, T, 30'h3c);
        ex(OP_RCPL, 3'h0, 3'h3, 30'hf, 30'h33, 30'h3c, F, F, T, 30'h33);
        ex(OP_RCLR, 3'h0, 3'h3, 30'h3, 30'h30, 30'h3c, F, F, T, 30'h30);
        ex(OP_RSUB, 3'h0, 3'h3, 30'hf, 30'hc, 30'h3c, F, F, T, 30'hc);
        $display("test selective done");
        for (int j = 0; j < 8; j++) begin
            pre(30'h3ffffffe, 30'h2);
            ex(OP_ADDQ, 3'(j), 3'h0, 30'h5, 30'h3ffffffe, 30'h7, TBL[j], F, F, '0);
        end
        pre(30'h5, 30'h7);
        ex(OP_SUBQ, 3'h6, 3'h0, 30'h5, 30'h5, 30'h2, T, F, F, '0);
        $display("test q skips done");
        pre(30'h5, 30'h3ffffff0);
        for (int j = 0; j < 8; j++) begin
            ex(OP_JMPA, 3'(j), 3'h0, 30'h0, 30'h5, 30'h3ffffff0, F, TBL[j], F, '0);
        end
        yv = 15'h040;
        for (int j = 0; j < 8; j++) begin
            if (TBL[j]) last = pexp + 15'h1;
            ex(OP_RJMP, 3'(j), 3'h0, 30'h0, 30'h5, 30'h3ffffff0, F, TBL[j], TBL[j],
                {15'h0, pexp + 15'h1});
        end
        `CHK(rd_word, {15'h5555, last});
        yv = 15'h020;
        $display("test arithmetic jumps done");
        jsel = 3'b010;
        ssel = 3'b010;
        repeat (5) @(posedge mclk);
        #1;
        for (int j = 0; j < 8; j++) begin
            ex(OP_JMPM, 3'(j), 3'h0, 30'h0, 30'h5, 30'h3ffffff0, F, KT[j], F, '0);
        end
        in_act = 8'h04;
        out_act = 8'h20;
        ex(OP_JBIN, 3'h2, 3'h2, 30'h0, 30'h5, 30'h3ffffff0, F, T, F, '0);
        ex(OP_JBIN, 3'h3, 3'h0, 30'h0, 30'h5, 30'h3ffffff0, F, F, F, '0);
        ex(OP_JBOUT, 3'h5, 3'h1, 30'h0, 30'h5, 30'h3ffffff0, F, T, F, '0);
        ex(OP_JBOUT, 3'h2, 3'h3, 30'h0, 30'h5, 30'h3ffffff0, F, F, F, '0);
        $display("test key and buffer jumps done");
        ce = 1'b0;
        instr = '{op: OP_EYPQ, j: 3'h0, k: 3'h0, y: yv, opnd: 30'h1};
        go = 1'b1;
        @(posedge mclk);
        #1;
        `CHK({done, a_reg}, {F, 30'h5});
        go = 1'b0;
        ce = 1'b1;
        $display("test clock enable done");
        instr = '{op: OP_SSET, j: 3'h0, k: 3'h0, y: yv, opnd: 30'h30};
        go = 1'b1;
        @(posedge mclk);
        #1;
        instr.opnd = 30'h3;
        @(posedge mclk);
        #1;
        `CHK({done, a_reg}, {T, 30'h37});
        `CHK(p_reg, pexp + 15'h2);
        go = 1'b0;
        @(posedge mclk);
        #1;
        `CHK(done, F);
        $display("test back to back done");
        give_verdict();
    end

    initial begin
        #20000;
        mismatches++;
        $display("mismatch at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule
